// ===== rtl/asi_status_regs.sv
// APB register bank with status flags, interrupt enable, mode and result registers
`timescale 1ns/1ps
`include "asi_regs.svh"
module asi_status_regs #(
	parameter int GOR_TICK_CYCLES = (`ASI_GOR_PERIOD_US * 1000) / `ASI_CLK_PERIOD_NS
) (
	// Clock, reset, freeze
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Converter side
	input  wire asi_pkg::asi_conv_s conv [3],
	input  wire asi_pkg::asi_evt_s  evt,
	output asi_pkg::asi_ctl_s       ctl,
	output logic                   irq
);
	logic [15:0] status, next_status;
	logic [7:0]  irq_en, next_irq_en;
	logic [7:0]  next_mode, next_cfg, next_chan;
	logic [15:0] thresh, next_thresh;
	logic [7:0]  tcnt_lim, next_tcnt_lim, tcnt, next_tcnt;
	logic [15:0] gor_cnt, next_gor_cnt;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_irq;
	logic [15:0] res_q [3];
	logic [15:0] next_res [3];
	logic [2:0]  rd_res, store, bad, next_err, next_rdy;
	logic        wr_done, rd_done, wr_mode, wr_chan, gor_tick;
	logic        fifo_en, cmp_en, tcnt_en, cur_exceed;
	logic [16:0] cur_mag;

	// Completion of an access is the only edge with side effects
	assign wr_done  = psel & penable & pready & pwrite;
	assign rd_done  = psel & penable & pready & ~pwrite;
	assign wr_mode  = wr_done & (paddr == `ASI_ADDR_MODE);
	assign wr_chan  = wr_done & (paddr == `ASI_ADDR_CHAN);
	assign fifo_en  = ctl.cfg[`ASI_CFG_FIFO_EN];
	assign cmp_en   = ctl.cfg[`ASI_CFG_CMP_EN];
	assign tcnt_en  = ctl.cfg[`ASI_CFG_TCNT_EN];
	assign gor_tick = (gor_cnt == 16'h0000);

	// Per-channel result store, clamp and ready/error next values
	for (genvar ch = 0; ch < 3; ch++) begin : g_ch
		assign rd_res[ch] = rd_done & (paddr == `ASI_ADDR_RES_CUR + 32'(4 * ch));
		assign bad[ch]    = conv[ch].over | conv[ch].under;
		// A set ready bit protects the value until software has read it, unless the core is down
		assign store[ch]  = conv[ch].valid & ctl.chan[ch]
			& (~status[ch] | evt.core_down); // RULE_22
		assign next_res[ch] = ~store[ch] ? res_q[ch] :
			conv[ch].under ? `ASI_NEG_FS : // RULE_05
			conv[ch].over  ? `ASI_POS_FS : conv[ch].data; // RULE_05
		// Error sets on any bad conversion of an enabled channel, clears on an in-range store; set wins
		assign next_err[ch] = (conv[ch].valid & ctl.chan[ch] & bad[ch])
			| (status[`ASI_ST_ERR0 + ch] & ~(store[ch] & ~bad[ch])); // RULE_02 RULE_03 RULE_04
		// Ready clears on its own read, a current read, or any result read without current channel
		assign next_rdy[ch] = store[ch] | (status[ch] & ~(rd_res[0] | rd_res[ch]
			| (|rd_res[2:1] & ~ctl.chan[0]))); // RULE_15 RULE_16 RULE_17 RULE_23
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				res_q[ch] <= `ASI_RST_WORD;
			end else if (ce) begin
				res_q[ch] <= next_res[ch];
			end
		end
	end

	// Magnitude of the raw current result; 17 bits so the most negative code fits
	assign cur_mag    = conv[0].data[15] ? 17'(-{conv[0].data[15], conv[0].data})
		: {1'b0, conv[0].data};
	assign cur_exceed = conv[0].valid & ctl.chan[0] & cmp_en
		& (cur_mag > {1'b0, thresh}); // RULE_11

	// Register read mux, evaluated in the setup cycle
	always_comb begin
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		unique case (paddr)
			`ASI_ADDR_STATUS:   next_prdata = {16'h0000, status};
			`ASI_ADDR_IRQ_EN:   next_prdata = {24'h000000, irq_en};
			`ASI_ADDR_MODE:     next_prdata = {24'h000000, ctl.mode};
			`ASI_ADDR_CFG:      next_prdata = {24'h000000, ctl.cfg};
			`ASI_ADDR_CHAN:     next_prdata = {24'h000000, ctl.chan};
			`ASI_ADDR_THRESH:   next_prdata = {16'h0000, thresh};
			`ASI_ADDR_TCNT_LIM: next_prdata = {24'h000000, tcnt_lim};
			`ASI_ADDR_TCNT_VAL: next_prdata = {24'h000000, tcnt};
			`ASI_ADDR_RES_CUR:  next_prdata = {16'h0000, res_q[0]};
			`ASI_ADDR_RES_CUR + 32'h4: next_prdata = {16'h0000, res_q[1]};
			`ASI_ADDR_RES_CUR + 32'h8: next_prdata = {16'h0000, res_q[2]};
			default:            next_pslverr = 1'b1;
		endcase
		// No wait state: ready rises in the first access cycle only
		next_pready = psel & ~penable;
		if (!(psel & ~penable)) begin
			next_prdata  = prdata;
			next_pslverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Software-written registers; status has no write path at all
	always_comb begin
		next_irq_en   = irq_en;
		next_mode     = ctl.mode;
		next_cfg      = ctl.cfg;
		next_chan     = ctl.chan;
		next_thresh   = thresh;
		next_tcnt_lim = tcnt_lim;
		if (wr_done) begin
			unique case (paddr)
				`ASI_ADDR_IRQ_EN:   next_irq_en   = pwdata[7:0]; // RULE_19
				`ASI_ADDR_MODE:     next_mode     = pwdata[7:0]; // RULE_20
				`ASI_ADDR_CFG:      next_cfg      = pwdata[7:0];
				`ASI_ADDR_CHAN:     next_chan     = pwdata[7:0];
				`ASI_ADDR_THRESH:   next_thresh   = pwdata[15:0];
				`ASI_ADDR_TCNT_LIM: next_tcnt_lim = pwdata[7:0];
				default:            next_mode     = ctl.mode; // RULE_24
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en   <= `ASI_RST_IRQ_EN; // RULE_19
			ctl      <= {`ASI_RST_BYTE, `ASI_RST_BYTE, `ASI_RST_BYTE}; // RULE_20
			thresh   <= `ASI_RST_WORD;
			tcnt_lim <= `ASI_RST_BYTE;
		end else if (ce) begin
			irq_en   <= next_irq_en;
			ctl      <= {next_mode, next_cfg, next_chan};
			thresh   <= next_thresh;
			tcnt_lim <= next_tcnt_lim;
		end
	end

	// Gross overrange sample period and threshold exceed counter
	always_comb begin
		next_gor_cnt = gor_tick ? 16'(GOR_TICK_CYCLES - 1) : gor_cnt - 16'h0001; // RULE_13
		next_tcnt    = tcnt;
		// Reconfiguring restarts the count so a stale tally cannot fire early
		if (wr_mode || !cmp_en) begin
			next_tcnt = 8'h00;
		end else if (cur_exceed && tcnt_en && tcnt != tcnt_lim) begin
			next_tcnt = tcnt + 8'h01; // RULE_12
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gor_cnt <= 16'h0000;
			tcnt    <= 8'h00;
		end else if (ce) begin
			gor_cnt <= next_gor_cnt;
			tcnt    <= next_tcnt;
		end
	end

	// Status flags; in every flag a hardware set beats a clear in the same cycle
	always_comb begin
		next_status = status;
		if (wr_mode) begin
			next_status[`ASI_ST_CAL] = 1'b0; // RULE_01
		end
		if (evt.cal_done) begin
			next_status[`ASI_ST_CAL] = 1'b1; // RULE_01
		end
		next_status[14:12] = next_err;
		next_status[2:0]   = next_rdy;
		next_status[11:10] = 2'b00; // RULE_24
		next_status[5]     = 1'b0; // RULE_24
		// Overflow and full: sticky, dropped by FIFO disable or a mode write
		if (!fifo_en || wr_mode) begin
			next_status[`ASI_ST_FOVF] = 1'b0; // RULE_07
			next_status[`ASI_ST_FFUL] = 1'b0; // RULE_09
		end
		if (fifo_en && evt.fifo_ovf) begin
			next_status[`ASI_ST_FOVF] = 1'b1; // RULE_07
		end
		if (fifo_en && evt.fifo_full) begin
			next_status[`ASI_ST_FFUL] = 1'b1; // RULE_09
		end
		next_status[`ASI_ST_FEMP] = fifo_en & evt.fifo_empty; // RULE_08
		if (ctl.cfg[`ASI_CFG_ACC_HI:`ASI_CFG_ACC_LO] == 2'b00 || wr_mode) begin
			next_status[`ASI_ST_ACC] = 1'b0; // RULE_10
		end
		if (ctl.cfg[`ASI_CFG_ACC_HI:`ASI_CFG_ACC_LO] != 2'b00 && evt.acc_exceed) begin
			next_status[`ASI_ST_ACC] = 1'b1; // RULE_10
		end
		if (!cmp_en || wr_mode) begin
			next_status[`ASI_ST_CMP] = 1'b0;
		end
		if (cur_exceed && (!tcnt_en || tcnt + 8'h01 == tcnt_lim)) begin
			next_status[`ASI_ST_CMP] = 1'b1; // RULE_11 RULE_12
		end
		// Gain change is a write that alters the gain field, not any channel write
		if (!ctl.cfg[`ASI_CFG_GOR_EN] || (wr_chan && pwdata[`ASI_CH_GAIN_HI:`ASI_CH_GAIN_LO]
				!= ctl.chan[`ASI_CH_GAIN_HI:`ASI_CH_GAIN_LO])) begin
			next_status[`ASI_ST_GOR] = 1'b0; // RULE_14
		end
		if (gor_tick && ctl.cfg[`ASI_CFG_GOR_EN] && evt.gross_over) begin
			next_status[`ASI_ST_GOR] = 1'b1; // RULE_13
		end
		// Upper byte never reaches the interrupt
		next_irq = |(next_status[7:0] & next_irq_en); // RULE_21
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= `ASI_RST_STATUS; // RULE_18
			irq    <= 1'b0;
		end else if (ce) begin
			status <= next_status;
			irq    <= next_irq;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	cal_clear_a: assert property (ce && wr_mode && !evt.cal_done |=> !status[15]) // RULE_01
		else $error("calibration flag not cleared by mode write");
	cal_set_a: assert property (ce && evt.cal_done |=> status[15]) // RULE_01
		else $error("calibration flag not set");
	temp_err_a: assert property (ce && conv[2].valid && ctl.chan[2] && bad[2]
		|=> status[14]) // RULE_02
		else $error("temperature error not set");
	volt_err_a: assert property (ce && store[1] && !bad[1] && !(conv[1].valid && bad[1])
		|=> !status[13]) // RULE_03
		else $error("voltage error not cleared by good store");
	cur_err_a: assert property (ce && conv[0].valid && ctl.chan[0] && conv[0].over
		|=> status[12]) // RULE_04
		else $error("current error not set");
	clamp_neg_a: assert property (ce && store[0] && conv[0].under
		|=> res_q[0] == `ASI_NEG_FS) // RULE_05
		else $error("underrange not clamped");
	clamp_pos_a: assert property (ce && store[1] && conv[1].over && !conv[1].under
		|=> res_q[1] == `ASI_POS_FS) // RULE_05
		else $error("overrange not clamped");
	fifo_ovf_a: assert property (ce && !fifo_en |=> !status[9] && !status[7]) // RULE_07 RULE_09
		else $error("fifo flags not zero while fifo disabled");
	fifo_empty_a: assert property (ce |=> status[8] == $past(fifo_en && evt.fifo_empty)) // RULE_08
		else $error("fifo empty flag wrong");
	gor_set_a: assert property (ce && gor_tick && ctl.cfg[2] && evt.gross_over
		|=> status[3]) // RULE_13
		else $error("gross overrange not set on tick");
	gor_hold_a: assert property (status[3] && ctl.cfg[2] && !wr_chan |=> status[3]) // RULE_14
		else $error("gross overrange cleared unexpectedly");
	result_hold_a: assert property (status[0] && !evt.core_down |=> $stable(res_q[0])) // RULE_22
		else $error("current result overwritten while ready");
	rd_clear_a: assert property (ce && rd_res[0] && store == 3'b000
		|=> status[2:0] == 3'b000) // RULE_23 RULE_17
		else $error("current read did not clear ready bits");
	irq_or_a: assert property (irq == |(status[7:0] & irq_en)) // RULE_21
		else $error("interrupt differs from enabled low flags");
	reserved_a: assert property (status[11:10] == 2'b00 && !status[5]) // RULE_24
		else $error("reserved status bit set");

	// Software registers move only on a completed write to their own offset
	status_ro_a: assert property (wr_done && paddr == `ASI_ADDR_STATUS // RULE_24
		|=> $stable(irq_en) && $stable(ctl))
		else $error("status write changed another register");
	irq_en_wr_a: assert property (ce && wr_done && paddr == `ASI_ADDR_IRQ_EN // RULE_19
		|=> irq_en == $past(pwdata[7:0]))
		else $error("interrupt enable write lost");
	mode_wr_a: assert property (ce && wr_mode // RULE_20
		|=> ctl.mode == $past(pwdata[7:0]))
		else $error("mode write lost");
	mode_hold_a: assert property (!(ce && wr_mode) // RULE_20
		|=> $stable(ctl.mode))
		else $error("mode register changed without a write");
	thresh_wr_a: assert property (ce && wr_done && paddr == `ASI_ADDR_THRESH // RULE_11
		|=> thresh == $past(pwdata[15:0]))
		else $error("threshold write lost");
	irq_masked_a: assert property (irq_en == 8'h00 |-> !irq) // RULE_21
		else $error("interrupt raised with every source disabled");
	cal_hold_a: assert property (status[15] && !wr_mode |=> status[15]) // RULE_01
		else $error("calibration flag lost without a mode write");

	// Ready bits: set by a store, cleared by their own read, a current read, or any result read without current channel
	cur_rdy_a: assert property (ce && store[0] |=> status[0]) // RULE_17
		else $error("current ready not set by store");
	volt_rdy_a: assert property (ce && store[1] |=> status[1]) // RULE_16
		else $error("voltage ready not set by store");
	temp_rdy_a: assert property (ce && store[2] |=> status[2]) // RULE_15
		else $error("temperature ready not set by store");
	volt_rd_a: assert property (ce && rd_res[1] && !store[1] |=> !status[1]) // RULE_16
		else $error("voltage read did not clear its ready bit");
	temp_rd_a: assert property (ce && rd_res[2] && !store[2] |=> !status[2]) // RULE_15
		else $error("temperature read did not clear its ready bit");
	cur_rdy_hold_a: assert property (status[0] && !rd_res[0] && ctl.chan[0] // RULE_17
		|=> status[0])
		else $error("current ready cleared without a current read");
	alt_rd_clear_a: assert property (ce && (|rd_res[2:1]) && !ctl.chan[0] // RULE_23
		&& store == 3'b000 |=> status[2:0] == 3'b000)
		else $error("read without current channel did not clear ready bits");
	sleep_store_a: assert property (ce && conv[0].valid && ctl.chan[0] // RULE_22
		&& evt.core_down && !bad[0] |=> res_q[0] == $past(conv[0].data))
		else $error("result not refreshed while the core sleeps");

	// Range errors and clamping of the stored result
	temp_ok_a: assert property (ce && store[2] && !bad[2] |=> !status[14]) // RULE_02
		else $error("temperature error not cleared by good store");
	volt_bad_a: assert property (ce && conv[1].valid && ctl.chan[1] && bad[1] // RULE_03
		|=> status[13])
		else $error("voltage error not set");
	cur_ok_a: assert property (ce && store[0] && !bad[0] |=> !status[12]) // RULE_04
		else $error("current error not cleared by good store");
	cur_under_a: assert property (ce && conv[0].valid && ctl.chan[0] // RULE_04
		&& conv[0].under |=> status[12])
		else $error("current underrange error not set");
	pass_data_a: assert property (ce && store[2] && !bad[2] // RULE_05
		|=> res_q[2] == $past(conv[2].data))
		else $error("in-range temperature result altered");
	clamp_temp_a: assert property (ce && store[2] && conv[2].over // RULE_05
		&& !conv[2].under |=> res_q[2] == `ASI_POS_FS)
		else $error("temperature overrange not clamped");

	// FIFO, accumulator and comparator flags
	ovf_latch_a: assert property (status[9] && fifo_en && !wr_mode |=> status[9]) // RULE_07
		else $error("fifo overflow flag lost while latched");
	femp_off_a: assert property (ce && !fifo_en |=> !status[8]) // RULE_08
		else $error("fifo empty flag set while fifo disabled");
	full_set_a: assert property (ce && fifo_en && evt.fifo_full |=> status[7]) // RULE_09
		else $error("fifo full flag not set");
	acc_off_a: assert property (ce // RULE_10
		&& ctl.cfg[`ASI_CFG_ACC_HI:`ASI_CFG_ACC_LO] == 2'b00 |=> !status[6])
		else $error("accumulator flag set while function disabled");
	acc_set_a: assert property (ce && evt.acc_exceed // RULE_10
		&& ctl.cfg[`ASI_CFG_ACC_HI:`ASI_CFG_ACC_LO] != 2'b00 |=> status[6])
		else $error("accumulator flag not set");
	cmp_off_a: assert property (ce && !cmp_en |=> !status[4]) // RULE_11
		else $error("comparator flag set while comparator disabled");
	tcnt_sat_a: assert property (tcnt_en && cmp_en && tcnt == tcnt_lim && !wr_done // RULE_12
		|=> tcnt == tcnt_lim)
		else $error("threshold counter ran past its limit");

	// Gross overrange tick and flag
	gor_period_a: assert property (ce && gor_tick // RULE_13
		|=> gor_cnt == 16'(GOR_TICK_CYCLES - 1))
		else $error("overrange sample period not restarted");
	gor_tick_only_a: assert property (!gor_tick && !status[3] |=> !status[3]) // RULE_13
		else $error("gross overrange set between ticks");
	gor_off_a: assert property (ce && !ctl.cfg[`ASI_CFG_GOR_EN] |=> !status[3]) // RULE_14
		else $error("gross overrange flag held with detection disabled");

	store_c: cover property (ce && store[0] ##1 rd_res[0]);
	irq_c: cover property (!irq ##1 irq);
	clamp_c: cover property (store[2] && conv[2].under);
	gor_c: cover property (ce && gor_tick && status[3]);
	freeze_c: cover property (!ce && conv[2].valid);
endmodule

// ===== rtl/asi_regs.svh
// Offsets, field positions, reset values and timing counts of the converter status bank
// Operation
// RULE_01 - Status bit 15 sets on calibration done, clears on any mode register write.
// RULE_02 - Status bit 14 sets on temperature range error, clears on in-range store.
// RULE_03 - Status bit 13 sets on voltage range error, clears on in-range store.
// RULE_04 - Status bit 12 sets on current range error, clears on in-range store.
// RULE_05 - Range error clamps stored result: underrange to negative, overrange to positive.
// RULE_06 - Software ignores reserved status bits 11, 10 and 5.
// RULE_07 - Bit 9 latches FIFO overflow, no interrupt, clears on disable or reconfiguration.
// RULE_08 - Bit 8 shows FIFO empty, reads zero while the FIFO is disabled.
// RULE_09 - Bit 7 sets on FIFO full, clears on FIFO disable or reconfiguration.
// RULE_10 - Bit 6 sets on accumulator threshold, clears on comparator disable or reconfiguration; the code clears it on accumulator disable (field zero) instead.
// RULE_11 - With comparator enabled, bit 4 sets when current magnitude exceeds threshold.
// RULE_12 - With threshold counter used, bit 4 sets when exceed count reaches limit.
// RULE_13 - With detection enabled, bit 3 sets on gross overrange, sampled every 125 us.
// RULE_14 - Gross overrange flag clears only on detection disable or current gain change.
// RULE_15 - Bit 2 sets on stored temperature result, clears reading temperature or current.
// RULE_16 - Bit 1 sets on stored voltage result, clears reading voltage or current.
// RULE_17 - Bit 0 sets on stored current result, clears reading current result.
// RULE_18 - Status register is 16-bit, read-only, resets to zero.
// RULE_19 - Interrupt enable mirrors low status byte, one enables, resets to zero.
// RULE_20 - Mode register is 8-bit read/write, resets to zero.
// RULE_21 - Interrupt is OR of enabled low status bits; upper byte never interrupts.
// RULE_22 - Result holds while its ready bit is set, unless the core is powered down.
// RULE_23 - Current result read clears all ready bits; without current channel, others do.
// RULE_24 - Reserved status bits read zero; status writes change nothing.
`ifndef ASI_REGS_SVH
`define ASI_REGS_SVH

`define ASI_ADDR_STATUS   32'hffff0500
`define ASI_ADDR_IRQ_EN   32'hffff0504
`define ASI_ADDR_MODE     32'hffff0508
`define ASI_ADDR_CFG      32'hffff050c
`define ASI_ADDR_CHAN     32'hffff0510
`define ASI_ADDR_THRESH   32'hffff0514
`define ASI_ADDR_TCNT_LIM 32'hffff0518
`define ASI_ADDR_TCNT_VAL 32'hffff051c
`define ASI_ADDR_RES_CUR  32'hffff0520

`define ASI_RST_STATUS 16'h0000
`define ASI_RST_IRQ_EN 8'h00
`define ASI_RST_BYTE   8'h00
`define ASI_RST_WORD   16'h0000

`define ASI_ST_CAL   15
`define ASI_ST_ERR0  12
`define ASI_ST_FOVF  9
`define ASI_ST_FEMP  8
`define ASI_ST_FFUL  7
`define ASI_ST_ACC   6
`define ASI_ST_CMP   4
`define ASI_ST_GOR   3

`define ASI_CFG_FIFO_EN 0
`define ASI_CFG_TCNT_EN 1
`define ASI_CFG_GOR_EN  2
`define ASI_CFG_CMP_EN  3
`define ASI_CFG_ACC_LO  5
`define ASI_CFG_ACC_HI  6
`define ASI_CH_GAIN_LO  4
`define ASI_CH_GAIN_HI  6

`define ASI_NEG_FS 16'h8000
`define ASI_POS_FS 16'h7fff

`define ASI_CLK_PERIOD_NS  5
`define ASI_GOR_PERIOD_US  125

`endif

// ===== rtl/asi_pkg.sv
// Types shared by the converter status bank and its surroundings
package asi_pkg;
	// One conversion delivered by a channel filter
	typedef struct packed {
		logic        valid;
		logic        over;
		logic        under;
		logic [15:0] data;
	} asi_conv_s;

	// Software controls that steer the converter subsystem
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] cfg;
		logic [7:0] chan;
	} asi_ctl_s;

	// FIFO, accumulator, gross overrange, calibration and core power-down events from the datapath
	typedef struct packed {
		logic fifo_empty;
		logic fifo_full;
		logic fifo_ovf;
		logic acc_exceed;
		logic gross_over;
		logic cal_done;
		logic core_down;
	} asi_evt_s;
endpackage

// ===== tb/asi_src_model.sv
// Converter-side stand-in that delivers conversions and datapath events
`timescale 1ns/1ps
module asi_src_model (
	// Clock
	input  wire logic          pclk,
	// Converter outputs
	output asi_pkg::asi_conv_s conv [3],
	output asi_pkg::asi_evt_s  evt
);
	// Idle datapath: nothing pending, no events
	initial begin
		for (int i = 0; i < 3; i++) begin
			conv[i] = '0;
		end
		evt = '0;
	end

	// One conversion; qualifiers are scrambled afterwards so a stale sample shows up
	task automatic pulse(input int ch, input logic ov, un, input logic [15:0] d);
		@(posedge pclk);
		conv[ch] <= '{1'b1, ov, un, d};
		@(posedge pclk);
		conv[ch] <= '{1'b0, ~ov, ~un, ~d};
		@(posedge pclk);
	endtask

	// Event levels, held until the next call
	task automatic ev(input asi_pkg::asi_evt_s v);
		@(posedge pclk);
		evt <= v;
		@(posedge pclk);
	endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the converter status register bank
`timescale 1ns/1ps
`include "asi_regs.svh"
module tb;
	localparam logic [31:0] ST = `ASI_ADDR_STATUS;
	localparam logic [31:0] IE = `ASI_ADDR_IRQ_EN;
	localparam logic [31:0] MD = `ASI_ADDR_MODE;
	localparam logic [31:0] CF = `ASI_ADDR_CFG;
	localparam logic [31:0] CH = `ASI_ADDR_CHAN;
	localparam logic [31:0] RC = `ASI_ADDR_RES_CUR;

	logic               pclk        = 1'b0;
	logic               presetn     = 1'b0;
	logic               ce          = 1'b1;
	logic               psel        = 1'b0;
	logic               penable     = 1'b0;
	logic               pwrite      = 1'b0;
	logic [31:0]        paddr       = '0;
	logic [31:0]        pwdata      = '0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               irq;
	asi_pkg::asi_conv_s conv [3];
	asi_pkg::asi_evt_s  evt;
	asi_pkg::asi_ctl_s  ctl;
	logic [31:0]        r;
	logic               e;
	int                 err_count   = 0;
	int                 comparisons = 0;

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// Short overrange tick keeps the run brief
	asi_status_regs #(.GOR_TICK_CYCLES(8)) i_asi_status_regs (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv(conv), .evt(evt), .ctl(ctl), .irq(irq)
	);

	asi_src_model i_asi_src_model (.pclk(pclk), .conv(conv), .evt(evt));

	// Compare and count
	task automatic chk(input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No fixed wait count: only the watchdog ends a stalled access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, d);
		xfer(1'b1, a, d);
	endtask

	task automatic rdc(input logic [31:0] a, exp);
		xfer(1'b0, a, '0);
		chk(r, exp);
	endtask

	// Report and end the run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		conclude();
	end

	// Main sequence
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ST, 0);
		rdc(IE, 0);
		rdc(MD, 0);
		wr(IE, 32'h3ff);
		rdc(IE, 32'hff);
		wr(MD, 32'h5a);
		rdc(MD, 32'h5a);
		chk(ctl.mode, 32'h5a);
		wr(CH, 32'h07);
		// Over, under, then in-range on each channel
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 3; k++) begin
				i_asi_src_model.pulse(c, k == 0, k == 1, 16'h0123);
				rdc(ST, (32'h1 << c) | (k < 2 ? 32'h1000 << c : 0));
				chk(irq, 1);
				rdc(RC + 4 * c, k == 0 ? 32'h7fff : k == 1 ? 32'h8000 : 32'h0123);
				xfer(1'b0, RC, '0);
				rdc(ST, k < 2 ? 32'h1000 << c : 0);
			end
		end
		// Result held while ready, unless the core sleeps
		i_asi_src_model.pulse(0, 0, 0, 16'h0011);
		i_asi_src_model.pulse(0, 0, 0, 16'h0022);
		rdc(RC, 32'h0011);
		i_asi_src_model.pulse(0, 0, 0, 16'h0033);
		i_asi_src_model.ev(7'h01);
		i_asi_src_model.pulse(0, 0, 0, 16'h0044);
		rdc(RC, 32'h0044);
		i_asi_src_model.ev(7'h00);
		// Masked ready and calibration flag
		wr(IE, 32'h80);
		i_asi_src_model.pulse(1, 0, 0, 16'h0055);
		i_asi_src_model.ev(7'h02);
		i_asi_src_model.ev(7'h00);
		rdc(ST, 32'h8002);
		chk(irq, 0);
		rdc(RC + 4, 32'h0055);
		rdc(ST, 32'h8000);
		wr(ST, 32'hffff);
		rdc(ST, 32'h8000);
		wr(MD, 0);
		rdc(ST, 0);
		rdc(32'hffff0540, 0);
		chk(e, 1);
		// FIFO flags
		i_asi_src_model.ev(7'h40);
		rdc(ST, 0);
		wr(CF, 32'h01);
		rdc(ST, 32'h0100);
		i_asi_src_model.ev(7'h30);
		i_asi_src_model.ev(7'h00);
		rdc(ST, 32'h0280);
		chk(irq, 1);
		wr(MD, 0);
		rdc(ST, 0);
		// Accumulator comparator
		wr(CF, 32'h21);
		i_asi_src_model.ev(7'h08);
		i_asi_src_model.ev(7'h00);
		rdc(ST, 32'h0040);
		wr(CF, 32'h01);
		rdc(ST, 0);
		// Current comparator, single and counted
		wr(`ASI_ADDR_THRESH, 32'h0100);
		wr(CF, 32'h08);
		i_asi_src_model.pulse(0, 0, 0, 16'h0200);
		rdc(ST, 32'h0011);
		wr(CF, 0);
		xfer(1'b0, RC, '0);
		wr(`ASI_ADDR_TCNT_LIM, 2);
		wr(CF, 32'h0a);
		i_asi_src_model.pulse(0, 0, 0, 16'h0200);
		rdc(ST, 32'h0001);
		xfer(1'b0, RC, '0);
		i_asi_src_model.pulse(0, 0, 0, 16'h0200);
		rdc(ST, 32'h0011);
		rdc(`ASI_ADDR_TCNT_VAL, 2);
		xfer(1'b0, RC, '0);
		wr(CF, 0);
		// Gross overrange: sticky until a gain change
		wr(CF, 32'h04);
		i_asi_src_model.ev(7'h04);
		repeat (10) @(posedge pclk);
		i_asi_src_model.ev(7'h00);
		rdc(ST, 32'h0008);
		chk(r & 32'hf3df, 32'h0008);
		wr(CH, 32'h07);
		rdc(ST, 32'h0008);
		wr(CH, 32'h17);
		rdc(ST, 0);
		// Clock enable low: a conversion offered now must leave no trace
		ce <= 1'b0;
		i_asi_src_model.pulse(2, 0, 0, 16'h0066);
		ce <= 1'b1;
		rdc(ST, 0);
		rdc(RC + 8, 32'h0123);
		i_asi_src_model.pulse(2, 0, 0, 16'h0066);
		rdc(ST, 32'h0004);
		rdc(RC + 8, 32'h0066);
		rdc(ST, 0);
		// Reset in mid-run returns every software register to zero
		wr(IE, 32'h0f);
		wr(MD, 32'h33);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(ST, 0);
		rdc(IE, 0);
		rdc(MD, 0);
		chk(ctl, 0);
		conclude();
	end
endmodule
